// >>> hie_top.sv
// Overview of operation
// - Sixteen-bit read/write receive byte threshold register
// - Threshold enable sets receive status past threshold
// - Enable bit 15 gates link change
// - Enable bit 14 gates transmit done
// - Enable bit 13 gates frame received
// - Enable bit 11 gates receive overrun
// - Enable bit 9 gates transmit stopped
// - Enable bit 8 gates receive stopped
// - Enable bit 6 gates transmit space available
// - Enable bit 5 gates wake frame
// - Enable bit 4 gates wake packet
// - Enable bit 3 gates linkup wake
// - Enable bit 2 gates energy wake
// - Bit 0 gates delayed energy, held until ready
// - Interrupt high while enabled status bit set
// - Write one clears status; reads change nothing
`timescale 1ns/1ps
`default_nettype none
`include "hie_consts.svh"

module hie_top (
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire logic [7:0] ADDR_I,
    input wire hie_pkg::hie_word_t WR_DATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output var hie_pkg::hie_word_t RD_DATA_O,
    input wire hie_pkg::hie_events_t EVENTS_I,
    input wire hie_pkg::hie_word_t RX_QUEUE_BYTES_I,
    input wire logic HOST_READY_I,
    output var logic INT_O
);

    // ----------------------------------------------------------------
    // Bus request and decode
    // ----------------------------------------------------------------
    hie_pkg::hie_bus_req_t req;
    logic wr_thr;
    logic wr_en;
    logic wr_stat;
    logic wr_clr;
    logic wr_rqc;

    assign req = '{addr: ADDR_I, wr_data: WR_DATA_I, wr: WR_I, rd: RD_I};
    assign wr_thr = req.wr && (req.addr == `HIE_OFS_RX_BYTE_THRESHOLD);
    assign wr_en = req.wr && (req.addr == `HIE_OFS_INT_ENABLE);
    assign wr_stat = req.wr && (req.addr == `HIE_OFS_INT_STATUS);
    assign wr_clr = req.wr && (req.addr == `HIE_OFS_INT_CLEAR);
    assign wr_rqc = req.wr && (req.addr == `HIE_OFS_RX_QUEUE_CONTROL);

    // ----------------------------------------------------------------
    // Software registers
    // ----------------------------------------------------------------
    hie_pkg::hie_word_t rx_byte_count_threshold;
    hie_pkg::hie_word_t interrupt_enable;
    hie_pkg::hie_word_t receive_queue_control;
    hie_pkg::hie_word_t interrupt_status;

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            rx_byte_count_threshold <= `HIE_RST_RX_BYTE_THRESHOLD;
        end else if (wr_thr) begin
            rx_byte_count_threshold <= req.wr_data;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            interrupt_enable <= `HIE_RST_INT_ENABLE;
        end else if (wr_en) begin
            interrupt_enable <= req.wr_data & `HIE_ENABLE_MASK;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            receive_queue_control <= `HIE_RST_RX_QUEUE_CONTROL;
        end else if (wr_rqc) begin
            receive_queue_control <= req.wr_data & `HIE_RQC_MASK;
        end
    end

    // ----------------------------------------------------------------
    // Byte threshold detector
    // ----------------------------------------------------------------
    logic over_thr;
    logic over_thr_d;
    logic thr_hit;

    // Comparison runs every cycle so a new threshold applies at once
    assign over_thr = receive_queue_control[`HIE_BIT_BYTE_THRESHOLD_EN]
                      && (RX_QUEUE_BYTES_I > rx_byte_count_threshold);
    // Status is edge triggered: fire once when crossing upward
    assign thr_hit = over_thr && !over_thr_d;

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            over_thr_d <= 1'b0;
        end else begin
            over_thr_d <= over_thr;
        end
    end

    // ----------------------------------------------------------------
    // Status flags
    // ----------------------------------------------------------------
    hie_pkg::hie_word_t set_vec;
    hie_pkg::hie_word_t clr_vec;

    always_comb begin
        set_vec = 16'h0000;
        set_vec[`HIE_BIT_LINK_CHANGE] = EVENTS_I.link_change;
        set_vec[`HIE_BIT_TX_DONE] = EVENTS_I.tx_done;
        set_vec[`HIE_BIT_RX_FRAME] = EVENTS_I.rx_frame || thr_hit;
        set_vec[`HIE_BIT_RX_OVERRUN] = EVENTS_I.rx_overrun;
        set_vec[`HIE_BIT_TX_STOPPED] = EVENTS_I.tx_stopped;
        set_vec[`HIE_BIT_RX_STOPPED] = EVENTS_I.rx_stopped;
        set_vec[`HIE_BIT_TX_SPACE] = EVENTS_I.tx_space;
        set_vec[`HIE_BIT_WAKE_FRAME] = EVENTS_I.wake_frame;
        set_vec[`HIE_BIT_WAKE_PACKET] = EVENTS_I.wake_packet;
        set_vec[`HIE_BIT_LINKUP_WAKE] = EVENTS_I.linkup_wake;
        set_vec[`HIE_BIT_ENERGY_WAKE] = EVENTS_I.energy_wake;
    end

    // Write one to status or to the clear register; reads leave flags alone
    assign clr_vec = (wr_stat || wr_clr) ? req.wr_data : 16'h0000;

    hie_sticky_bits u_status (
        .clk_i(CLK_I),
        .rst_i(RST_I),
        .set_i(set_vec),
        .clr_i(clr_vec),
        .status_o(interrupt_status)
    );

    // ----------------------------------------------------------------
    // Interrupt gating
    // ----------------------------------------------------------------
    hie_pkg::hie_word_t gated;
    logic energy_plain;
    logic energy_delayed;

    always_comb begin
        gated = 16'h0000;
        gated[`HIE_BIT_LINK_CHANGE] = interrupt_status[`HIE_BIT_LINK_CHANGE]
                                      & interrupt_enable[`HIE_BIT_LINK_CHANGE];
        gated[`HIE_BIT_TX_DONE] = interrupt_status[`HIE_BIT_TX_DONE]
                                  & interrupt_enable[`HIE_BIT_TX_DONE];
        gated[`HIE_BIT_RX_FRAME] = interrupt_status[`HIE_BIT_RX_FRAME]
                                   & interrupt_enable[`HIE_BIT_RX_FRAME];
        gated[`HIE_BIT_RX_OVERRUN] = interrupt_status[`HIE_BIT_RX_OVERRUN]
                                     & interrupt_enable[`HIE_BIT_RX_OVERRUN];
        gated[`HIE_BIT_TX_STOPPED] = interrupt_status[`HIE_BIT_TX_STOPPED]
                                     & interrupt_enable[`HIE_BIT_TX_STOPPED];
        gated[`HIE_BIT_RX_STOPPED] = interrupt_status[`HIE_BIT_RX_STOPPED]
                                     & interrupt_enable[`HIE_BIT_RX_STOPPED];
        gated[`HIE_BIT_TX_SPACE] = interrupt_status[`HIE_BIT_TX_SPACE]
                                   & interrupt_enable[`HIE_BIT_TX_SPACE];
        gated[`HIE_BIT_WAKE_FRAME] = interrupt_status[`HIE_BIT_WAKE_FRAME]
                                     & interrupt_enable[`HIE_BIT_WAKE_FRAME];
        gated[`HIE_BIT_WAKE_PACKET] = interrupt_status[`HIE_BIT_WAKE_PACKET]
                                      & interrupt_enable[`HIE_BIT_WAKE_PACKET];
        gated[`HIE_BIT_LINKUP_WAKE] = interrupt_status[`HIE_BIT_LINKUP_WAKE]
                                      & interrupt_enable[`HIE_BIT_LINKUP_WAKE];
        gated[`HIE_BIT_ENERGY_WAKE] = energy_plain || energy_delayed;
    end

    // Energy flag: plain wake when only bit 2 enabled, delayed mode needs bits 2 and 0
    assign energy_plain = interrupt_status[`HIE_BIT_ENERGY_WAKE]
                          && interrupt_enable[`HIE_BIT_ENERGY_WAKE]
                          && !interrupt_enable[`HIE_BIT_DELAYED_ENERGY];
    // Delayed energy held back until the device can take host access
    assign energy_delayed = interrupt_status[`HIE_BIT_ENERGY_WAKE]
                            && interrupt_enable[`HIE_BIT_ENERGY_WAKE]
                            && interrupt_enable[`HIE_BIT_DELAYED_ENERGY]
                            && HOST_READY_I;

    assign INT_O = |gated;

    // ----------------------------------------------------------------
    // Read port: data valid only in the cycle after the strobe
    // ----------------------------------------------------------------
    hie_pkg::hie_word_t next_rd_data;

    always_comb begin
        next_rd_data = 16'h0000;
        if (req.rd) begin
            unique case (req.addr)
                `HIE_OFS_RX_BYTE_THRESHOLD: next_rd_data = rx_byte_count_threshold;
                `HIE_OFS_INT_ENABLE: next_rd_data = interrupt_enable;
                `HIE_OFS_INT_STATUS: next_rd_data = interrupt_status;
                `HIE_OFS_RX_QUEUE_CONTROL: next_rd_data = receive_queue_control;
                default: next_rd_data = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            RD_DATA_O <= 16'h0000;
        end else begin
            RD_DATA_O <= next_rd_data;
        end
    end

endmodule // hie_top

`default_nettype wire

// >>> hie_consts.svh
`ifndef HIE_CONSTS_SVH
`define HIE_CONSTS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define HIE_OFS_RX_BYTE_THRESHOLD 8'h8e
`define HIE_OFS_INT_ENABLE 8'h90
`define HIE_OFS_INT_STATUS 8'h92
`define HIE_OFS_INT_CLEAR 8'h94
`define HIE_OFS_RX_QUEUE_CONTROL 8'h96

// ----------------------------------------------------------------
// Interrupt bit positions (status, clear and enable share them; bit 0 is enable only, threshold enable bit is in queue control)
// ----------------------------------------------------------------
`define HIE_BIT_LINK_CHANGE 15
`define HIE_BIT_TX_DONE 14
`define HIE_BIT_RX_FRAME 13
`define HIE_BIT_RX_OVERRUN 11
`define HIE_BIT_TX_STOPPED 9
`define HIE_BIT_RX_STOPPED 8
`define HIE_BIT_TX_SPACE 6
`define HIE_BIT_WAKE_FRAME 5
`define HIE_BIT_WAKE_PACKET 4
`define HIE_BIT_LINKUP_WAKE 3
`define HIE_BIT_ENERGY_WAKE 2
`define HIE_BIT_DELAYED_ENERGY 0
`define HIE_BIT_BYTE_THRESHOLD_EN 6

// ----------------------------------------------------------------
// Masks and reset values
// ----------------------------------------------------------------
`define HIE_STATUS_MASK 16'heb7c
`define HIE_ENABLE_MASK 16'hfffd
`define HIE_RQC_MASK 16'h0040
`define HIE_RST_RX_BYTE_THRESHOLD 16'h0000
`define HIE_RST_INT_ENABLE 16'h0000
`define HIE_RST_INT_STATUS 16'h0000
`define HIE_RST_RX_QUEUE_CONTROL 16'h0000

`endif

// >>> hie_pkg.sv
package hie_pkg;

    typedef logic [15:0] hie_word_t;

    // Single-cycle event pulses from the queue and power logic
    typedef struct packed {
        logic link_change;
        logic tx_done;
        logic rx_frame;
        logic rx_overrun;
        logic tx_stopped;
        logic rx_stopped;
        logic tx_space;
        logic wake_frame;
        logic wake_packet;
        logic linkup_wake;
        logic energy_wake;
    } hie_events_t;

    // Register bus request
    typedef struct packed {
        logic [7:0] addr;
        hie_word_t wr_data;
        logic wr;
        logic rd;
    } hie_bus_req_t;

endpackage

// >>> hie_sticky_bits.sv
`timescale 1ns/1ps
`default_nettype none
`include "hie_consts.svh"

module hie_sticky_bits (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire hie_pkg::hie_word_t set_i,
    input wire hie_pkg::hie_word_t clr_i,
    output var hie_pkg::hie_word_t status_o
);

    localparam logic [15:0] VALID = `HIE_STATUS_MASK;

    // ----------------------------------------------------------------
    // One sticky flag per implemented bit; a set beats a clear
    // ----------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 16; g = g + 1) begin : g_bit
            if (VALID[g]) begin : g_impl
                // Own flop per bit so each output bit has a single driver
                logic flag;
                always_ff @(posedge clk_i) begin
                    if (rst_i) begin
                        flag <= 1'b0;
                    end else if (set_i[g]) begin
                        flag <= 1'b1;
                    end else if (clr_i[g]) begin
                        flag <= 1'b0;
                    end
                end
                assign status_o[g] = flag;
            end else begin : g_rsvd
                assign status_o[g] = 1'b0;
            end
        end
    endgenerate

endmodule // hie_sticky_bits

`default_nettype wire

// >>> hie_top_sva.sv
`timescale 1ns/1ps
`default_nettype none
module hie_top_sva (
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire logic [7:0] ADDR_I,
    input wire hie_pkg::hie_word_t WR_DATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    input wire hie_pkg::hie_word_t RD_DATA_O,
    input wire hie_pkg::hie_events_t EVENTS_I,
    input wire hie_pkg::hie_word_t RX_QUEUE_BYTES_I,
    input wire logic HOST_READY_I,
    input wire logic INT_O
);
    logic [15:0] en;
    logic [15:0] thr;
    default clocking @(posedge CLK_I); endclocking
    default disable iff (RST_I);
    // Shadow copies of the enable and threshold registers
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            en <= 16'h0000;
            thr <= 16'h0000;
        end else if (WR_I) begin
            if (ADDR_I == 8'h90) en <= WR_DATA_I & 16'hfffd;
            if (ADDR_I == 8'h8e) thr <= WR_DATA_I;
        end
    end
    chk_en_readback: assert property (RD_I && ADDR_I == 8'h90 |=> RD_DATA_O == $past(en))
        else $error("enable read back wrong");
    chk_thr_readback: assert property (RD_I && ADDR_I == 8'h8e |=> RD_DATA_O == $past(thr))
        else $error("threshold read back wrong");
    chk_status_rsvd: assert property (RD_I && ADDR_I == 8'h92 |=> (RD_DATA_O & 16'h1483) == 16'h0000)
        else $error("reserved status bit set");
    chk_unmapped_zero: assert property (RD_I && ADDR_I == 8'h94 |=> RD_DATA_O == 16'h0000)
        else $error("clear register read not zero");
    chk_int_off: assert property (en == 16'h0000 |-> !INT_O)
        else $error("interrupt with all enables off");
    chk_txdone_int: assert property (EVENTS_I.tx_done && en[14] && !WR_I |=> INT_O)
        else $error("transmit done did not interrupt");
    chk_link_int: assert property (EVENTS_I.link_change && en[15] && !WR_I |=> INT_O)
        else $error("link change did not interrupt");
    chk_int_sticky: assert property (INT_O && !WR_I && !en[0] |=> INT_O)
        else $error("interrupt dropped without a write");
    chk_int_rst: assert property ($fell(RST_I) |-> !INT_O)
        else $error("interrupt high after reset");
endmodule // hie_top_sva
`default_nettype wire

// >>> hie_host.sv
`timescale 1ns/1ps
`default_nettype none
module hie_host (
    input wire logic clk_i,
    input wire hie_pkg::hie_word_t rd_data_i,
    output logic [7:0] addr_o,
    output hie_pkg::hie_word_t wr_data_o,
    output logic wr_o,
    output logic rd_o
);
    initial begin
        addr_o = 8'h00;
        wr_data_o = 16'h0000;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end
    // Idle lines carry the inverse of the last value; status is cleared by writing ones
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_i);
        addr_o <= a;
        wr_data_o <= d;
        wr_o <= 1'b1;
        @(posedge clk_i);
        wr_o <= 1'b0;
        addr_o <= ~a;
        wr_data_o <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk_i);
        addr_o <= a;
        rd_o <= 1'b1;
        @(posedge clk_i);
        rd_o <= 1'b0;
        addr_o <= ~a;
        #1 d = rd_data_i;
    endtask
endmodule // hie_host
`default_nettype wire

// >>> hie_tb.sv
`timescale 1ns/1ps
`default_nettype none
module host_interrupt_enable_rx_byte_threshold_test;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr;
    hie_pkg::hie_word_t wdata, rdata, v, bytes = 16'h0000, lfsr = 16'h0033;
    logic wr_stb, rd_stb, irq, rdy = 1'b0;
    hie_pkg::hie_events_t ev = '0;
    int errors = 0, cmp_count = 0, cyc = 0, st = 0, en = 0;
    int sb[11] = '{15, 14, 13, 11, 9, 8, 6, 5, 4, 3, 2};
    logic [7:0] ofs[4] = '{8'h8e, 8'h90, 8'h92, 8'h96};
    initial forever #4 clk = ~clk;
    hie_host u_hie_host (.clk_i(clk), .rd_data_i(rdata), .addr_o(addr), .wr_data_o(wdata), .wr_o(wr_stb),
        .rd_o(rd_stb));
    hie_top u_hie_top (.CLK_I(clk), .RST_I(rst), .ADDR_I(addr), .WR_DATA_I(wdata), .WR_I(wr_stb), .RD_I(rd_stb),
        .RD_DATA_O(rdata), .EVENTS_I(ev), .RX_QUEUE_BYTES_I(bytes), .HOST_READY_I(rdy), .INT_O(irq));
    function automatic hie_pkg::hie_word_t rnd();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return lfsr & 16'h7ffe;
    endfunction
    function automatic logic m_int();
        return ((st & en & 16'heb78) != 0) || (st[2] && en[2] && (!en[0] || rdy));
    endfunction
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic cmp_rd(input string n, input logic [7:0] a, input logic [15:0] e);
        hie_pkg::hie_word_t g;
        u_hie_host.rd(a, g);
        cmp_count++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic cmp_int(input logic e);
        cmp_count++;
        if (irq !== e) begin
            errors++;
            $display("CHECK FAILED irq exp %b got %b", e, irq);
        end
    endtask
    task automatic wr(input logic [7:0] a, input int d);
        u_hie_host.wr(a, d[15:0]);
        if (a == 8'h90) en = d & 16'hfffd;
        if (a == 8'h92 || a == 8'h94) st = st & ~d;
        #1;
    endtask
    task automatic pulse(input int k);
        @(posedge clk);
        ev <= hie_pkg::hie_events_t'(11'h400 >> k);
        @(posedge clk);
        ev <= '0;
        st = st | (1 << sb[k]);
        #1;
    endtask
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        foreach (ofs[i]) cmp_rd("reset", ofs[i], 16'h0000);
        v = rnd();
        wr(8'h8e, v);
        cmp_rd("thr", 8'h8e, v);
        wr(8'h90, 16'hffff);
        cmp_rd("en", 8'h90, 16'hfffd);
        cmp_rd("clear", 8'h94, 16'h0000);
        wr(8'h80, 16'hffff);
        cmp_rd("thr", 8'h8e, v);
        $display("test registers done");
        for (int k = 0; k < 11; k++) begin
            wr(8'h90, 1 << sb[k]);
            pulse(k);
            cmp_int(m_int());
            cmp_rd("st", 8'h92, st[15:0]);
            cmp_rd("st", 8'h92, st[15:0]);
            wr(8'h94, st);
            cmp_int(m_int());
            wr(8'h90, 16'hffff ^ (1 << sb[k]));
            pulse(k);
            cmp_int(m_int());
            wr(8'h92, st);
        end
        $display("test sources done");
        wr(8'h90, 16'h0005);
        pulse(10);
        cmp_int(m_int());
        @(posedge clk);
        rdy <= 1'b1;
        @(posedge clk);
        #1 cmp_int(m_int());
        wr(8'h94, 16'h0004);
        $display("test delayed energy done");
        wr(8'h90, 16'h2000);
        v = rnd();
        wr(8'h8e, v);
        wr(8'h96, 16'h0040);
        @(posedge clk);
        bytes <= v;
        repeat (2) @(posedge clk);
        #1 cmp_int(1'b0);
        @(posedge clk);
        bytes <= v + 16'h0001;
        repeat (2) @(posedge clk);
        st = st | 16'h2000;
        #1 cmp_int(m_int());
        wr(8'h94, 16'h2000);
        wr(8'h8e, v + 16'h0001);
        wr(8'h8e, v);
        @(posedge clk);
        st = st | 16'h2000;
        #1 cmp_rd("st", 8'h92, st[15:0]);
        wr(8'h94, 16'h2000);
        wr(8'h96, 16'h0000);
        wr(8'h8e, 16'h0000);
        repeat (2) @(posedge clk);
        #1 cmp_int(1'b0);
        $display("test threshold done");
        end_sim();
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc > 5000) begin
            errors++;
            end_sim();
        end
    end
endmodule // host_interrupt_enable_rx_byte_threshold_test
bind hie_top hie_top_sva u_hie_top_sva (.CLK_I(CLK_I), .RST_I(RST_I), .ADDR_I(ADDR_I), .WR_DATA_I(WR_DATA_I),
    .WR_I(WR_I), .RD_I(RD_I), .RD_DATA_O(RD_DATA_O), .EVENTS_I(EVENTS_I), .RX_QUEUE_BYTES_I(RX_QUEUE_BYTES_I),
    .HOST_READY_I(HOST_READY_I), .INT_O(INT_O));
`default_nettype wire
